// ===== include/quad_enc_cfg.svh
/*
  Register offsets, field positions, reset values and codes of the
  quadrature encoder interface. Assumes inclusion by bare name.
*/
`ifndef QUAD_ENC_CFG_SVH
`define QUAD_ENC_CFG_SVH

// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_IOC 8'h04
`define ADDR_POS 8'h08
`define ADDR_ICAP 8'h0C
`define ADDR_GEC 8'h10
`define ADDR_EVT 8'h14

// encoder_control fields
`define CTRL_EN 15
`define CTRL_IDLE 13
`define CTRL_PIM_HI 12
`define CTRL_PIM_LO 10
`define CTRL_IMV_HI 9
`define CTRL_IMV_LO 8
`define CTRL_PRE_HI 6
`define CTRL_PRE_LO 4
`define CTRL_POL 3
`define CTRL_GATE 2
`define CTRL_CCM_HI 1
`define CTRL_CCM_LO 0
`define CTRL_WMASK 16'hBF7F
`define CTRL_RESET 16'h0000

// encoder_io_control fields
`define IOC_CAP 15
`define IOC_FLT 14
`define IOC_SWAP 8
`define IOC_HPOL 7
`define IOC_IPOL 6
`define IOC_BPOL 5
`define IOC_APOL 4
`define IOC_WMASK 16'hC1F0
`define IOC_RESET 16'h0000

// event register bits
`define EVT_INDEX 0
`define EVT_HOME 1
`define EVT_INIT 2

// position init mode codes
`define PIM_NONE 3'h0
`define PIM_RESET 3'h1
`define PIM_NEXT 3'h2
`define PIM_FIRST 3'h3
`define PIM_SECOND 3'h4
`define PIM_GEC 3'h5
`define PIM_MOD 3'h6
`define PIM_RSVD 3'h7

// counter control mode codes
`define CCM_QUAD 2'h0
`define CCM_EXTDIR 2'h1
`define CCM_EXTCNT 2'h2
`define CCM_TIMER 2'h3

`define IMV_OFF 2'h0
`define HSIZE_WORD 3'h2
`define PRE_FULL 7'h7F
`define PRE_MAXCODE 3'h7
`define FILT_LEN 3

`endif

// ===== include/quad_enc_pkg.sv
/*
  Types of the quadrature encoder interface: pin bundle, home
  sequencing states and the block's state outside the pin filters. Assumes the cfg
  header is compiled alongside.
*/
package quad_enc_pkg;

  typedef struct packed {
    logic a;
    logic b;
    logic index;
    logic home;
  } pins_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_ARMED = 2'b01,
    HS_SECOND = 2'b11
  } home_state_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] ioc;
    logic [31:0] pos;
    logic [31:0] icap;
    logic [31:0] gec;
    logic [2:0] evt;
    home_state_t hs;
    logic [6:0] pre;
    pins_t prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
  } qe_state_t;

endpackage

// ===== verilog/pin_filter.sv
/*
  One encoder input: two-flop synchroniser, polarity inversion and an
  optional all-samples-agree noise filter. Assumes a free pin input.
*/
`timescale 1ns/1ps
module pin_filter #(
  parameter int LEN = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and controls
  input wire logic pin_raw,
  input wire logic invert,
  input wire logic filter_en,
  // cleaned level
  output logic level
);
  typedef struct packed {
    logic [1:0] sync;
    logic [LEN-1:0] hist;
    logic level;
  } filt_t;

  filt_t s;
  filt_t next_s;
  logic pol_level;

  always_comb begin
    next_s = s;
    // first flop feeds only the second
    next_s.sync = {s.sync[0], pin_raw};
    pol_level = s.sync[1] ^ invert;
    next_s.hist = {s.hist[LEN-2:0], pol_level};
    if (!filter_en) begin
      next_s.level = pol_level;
    end else if (&s.hist) begin
      next_s.level = 1'b1;
    end else if (~|s.hist) begin
      next_s.level = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
endmodule

// ===== verilog/quad_encoder.sv
/*
  Quadrature encoder interface with AHB-Lite register slave: decoder,
  position counter, init modes, prescaler, gating and home capture.
  Assumes a single 100 MHz hclk and asynchronous pin inputs.
*/
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "quad_enc_cfg.svh"
module quad_encoder
  import quad_enc_pkg::*;
#(
  parameter int FILT_LEN = `FILT_LEN
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // encoder pins
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic index_input,
  input wire logic home_input,
  input wire logic ext_gate_input,
  // system
  input wire logic device_idle
);
  qe_state_t s;
  qe_state_t next_s;
  pins_t f;
  logic gate_f;
  logic sa, sb;
  logic [6:0] pre_mask;
  logic tick, run, tick_run;
  logic step, quad_up, cnt_en, up;
  logic idx_rise, home_rise, ab_match, match_clr;
  logic [2:0] pim_eff;
  logic [1:0] ccm;
  logic [3:0] pin_status;
  logic [2:0] evt_set;
  logic addr_ok;
  logic [31:0] rd;

  // polarity ahead of the filter; the gate pin is never inverted
  pin_filter #(.LEN(FILT_LEN)) u_fa (.hclk(hclk), .hresetn(hresetn),
    .pin_raw(phase_a_input), .invert(s.ioc[`IOC_APOL]),
    .filter_en(s.ioc[`IOC_FLT]), .level(f.a));
  pin_filter #(.LEN(FILT_LEN)) u_fb (.hclk(hclk), .hresetn(hresetn),
    .pin_raw(phase_b_input), .invert(s.ioc[`IOC_BPOL]),
    .filter_en(s.ioc[`IOC_FLT]), .level(f.b));
  pin_filter #(.LEN(FILT_LEN)) u_fi (.hclk(hclk), .hresetn(hresetn),
    .pin_raw(index_input), .invert(s.ioc[`IOC_IPOL]),
    .filter_en(s.ioc[`IOC_FLT]), .level(f.index));
  pin_filter #(.LEN(FILT_LEN)) u_fh (.hclk(hclk), .hresetn(hresetn),
    .pin_raw(home_input), .invert(s.ioc[`IOC_HPOL]),
    .filter_en(s.ioc[`IOC_FLT]), .level(f.home));
  pin_filter #(.LEN(FILT_LEN)) u_fg (.hclk(hclk), .hresetn(hresetn),
    .pin_raw(ext_gate_input), .invert(1'b0),
    .filter_en(s.ioc[`IOC_FLT]), .level(gate_f));

  always_comb begin
    next_s = s;
    ccm = s.ctrl[`CTRL_CCM_HI:`CTRL_CCM_LO];
    // external count and timer modes and the reserved code leave init mode inactive
    pim_eff = s.ctrl[`CTRL_PIM_HI:`CTRL_PIM_LO];
    if (ccm[1] || pim_eff == `PIM_RSVD) begin
      pim_eff = `PIM_NONE;
    end
    sa = s.ioc[`IOC_SWAP] ? f.b : f.a;
    sb = s.ioc[`IOC_SWAP] ? f.a : f.b;
    pin_status = {f.home, f.index, sb, sa};
    // prescaler: tick when the low code bits are all ones
    next_s.pre = s.pre + 7'h01;
    pre_mask = `PRE_FULL >> (`PRE_MAXCODE -
      s.ctrl[`CTRL_PRE_HI:`CTRL_PRE_LO]);
    tick = (s.pre & pre_mask) == pre_mask;
    run = s.ctrl[`CTRL_EN]
      && !(s.ctrl[`CTRL_IDLE] && device_idle)
      && (!s.ctrl[`CTRL_GATE] || gate_f);
    tick_run = tick && run;
    // exactly one phase changed; both changing is dropped
    step = (sa ^ s.prev.a) ^ (sb ^ s.prev.b);
    quad_up = sa ^ s.prev.b;
    idx_rise = f.index && !s.prev.index;
    home_rise = f.home && !s.prev.home;
    case (ccm)
      `CCM_QUAD: begin
        cnt_en = step;
        up = quad_up ^ s.ctrl[`CTRL_POL];
      end
      `CCM_EXTDIR: begin
        cnt_en = sa && !s.prev.a;
        up = sb;
      end
      `CCM_EXTCNT: begin
        cnt_en = sa && !s.prev.a;
        up = !s.ctrl[`CTRL_POL];
      end
      default: begin
        cnt_en = 1'b1;
        up = !s.ctrl[`CTRL_POL];
      end
    endcase
    case (s.ctrl[`CTRL_IMV_HI:`CTRL_IMV_LO])
      2'h3: ab_match = sb && sa;
      2'h2: ab_match = sb && !sa;
      2'h1: ab_match = !sb && sa;
      default: ab_match = 1'b0;
    endcase
    match_clr = (ccm == `CCM_QUAD) && f.index && ab_match;
    evt_set = '0;
    if (tick) begin
      next_s.prev = {sa, sb, f.index, f.home};
    end
    if (tick_run) begin
      if (cnt_en) begin
        if (pim_eff == `PIM_MOD && up && s.pos == s.gec) begin
          next_s.pos = '0;
        end else if (pim_eff == `PIM_MOD && !up && s.pos == '0) begin
          next_s.pos = s.gec;
        end else if (up) begin
          next_s.pos = s.pos + 32'h1;
        end else begin
          next_s.pos = s.pos - 32'h1;
        end
      end
      if (home_rise) begin
        evt_set[`EVT_HOME] = 1'b1;
        if (pim_eff == `PIM_FIRST || pim_eff == `PIM_SECOND) begin
          next_s.hs = HS_ARMED;
        end
      end
      if (match_clr) begin
        next_s.pos = '0;
      end else if (idx_rise) begin
        evt_set[`EVT_INDEX] = 1'b1;
        case (pim_eff)
          `PIM_RESET: next_s.pos = '0;
          `PIM_NEXT: next_s.pos = s.icap;
          `PIM_FIRST: begin
            if (s.hs == HS_ARMED) begin
              next_s.pos = s.icap;
              next_s.hs = HS_IDLE;
              evt_set[`EVT_INIT] = 1'b1;
            end
          end
          `PIM_SECOND: begin
            if (s.hs == HS_ARMED) begin
              next_s.hs = HS_SECOND;
            end else if (s.hs == HS_SECOND) begin
              next_s.pos = s.icap;
              next_s.hs = HS_IDLE;
              evt_set[`EVT_INIT] = 1'b1;
            end
          end
          default: next_s.pos = next_s.pos;
        endcase
      end
      if (pim_eff == `PIM_GEC && s.pos == s.gec) begin
        next_s.pos = '0;
      end
    end
    if (pim_eff != `PIM_FIRST && pim_eff != `PIM_SECOND) begin
      next_s.hs = HS_IDLE;
    end
    // read mux for the address phase
    case (haddr[7:0])
      `ADDR_CTRL: rd = {16'h0000, s.ctrl};
      `ADDR_IOC: rd = {16'h0000, s.ioc[15:4], pin_status};
      `ADDR_POS: rd = s.pos;
      `ADDR_ICAP: rd = s.icap;
      `ADDR_GEC: rd = s.gec;
      `ADDR_EVT: rd = {29'h0, s.evt};
      default: rd = 32'h0000_0000;
    endcase
    addr_ok = hsel && hready && htrans[1] && hsize == `HSIZE_WORD
      && haddr[31:8] == 24'h000000;
    next_s.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      next_s.wr_addr = haddr[7:0];
    end
    if (addr_ok && !hwrite) begin
      next_s.rdata = rd;
    end
    next_s.ready = 1'b1;
    // software write lands in the data phase; a set beats its clear
    next_s.evt = s.evt | evt_set;
    if (s.wr_pend) begin
      case (s.wr_addr)
        `ADDR_CTRL: next_s.ctrl = hwdata[15:0] & `CTRL_WMASK;
        `ADDR_IOC: next_s.ioc = hwdata[15:0] & `IOC_WMASK;
        `ADDR_POS: next_s.pos = hwdata;
        `ADDR_ICAP: next_s.icap = hwdata;
        `ADDR_GEC: next_s.gec = hwdata;
        `ADDR_EVT: next_s.evt = (s.evt & ~hwdata[2:0]) | evt_set;
        default: next_s.evt = next_s.evt;
      endcase
    end
    // capture outranks a same-cycle software write
    if (tick_run && home_rise && s.ioc[`IOC_CAP]) begin
      next_s.icap = s.pos;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ctrl <= `CTRL_RESET;
      s.ioc <= `IOC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.ready;
  assign hresp = 1'b0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_disabled_hold;
    (!s.ctrl[`CTRL_EN] && !s.wr_pend) |=> $stable(s.pos);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("position moved while disabled");

  property p_idle_hold;
    (s.ctrl[`CTRL_IDLE] && device_idle && !s.wr_pend) |=> $stable(s.pos);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("position moved in idle stop");

  property p_gate_hold;
    (s.ctrl[`CTRL_GATE] && !gate_f && !s.wr_pend) |=> $stable(s.pos);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("position moved with gate closed");

  property p_gec_clear;
    (tick_run && pim_eff == `PIM_GEC && s.pos == s.gec && !s.wr_pend)
      |=> s.pos == 32'h0;
  endproperty
  a_gec_clear: assert property (p_gec_clear)
    else $error("compare equal did not clear position");

  property p_next_load;
    (tick_run && pim_eff == `PIM_NEXT && idx_rise && !match_clr
      && !s.wr_pend) |=> s.pos == $past(s.icap);
  endproperty
  a_next_load: assert property (p_next_load)
    else $error("index did not load position");

  property p_index_clear;
    (tick_run && pim_eff == `PIM_RESET && idx_rise && !s.wr_pend)
      |=> s.pos == 32'h0;
  endproperty
  a_index_clear: assert property (p_index_clear)
    else $error("index did not clear position");

  property p_match_clear;
    (tick_run && match_clr && pim_eff != `PIM_GEC && !s.wr_pend)
      |=> s.pos == 32'h0;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("index match did not clear position");

  property p_pre_two;
    (tick && s.ctrl[`CTRL_PRE_HI:`CTRL_PRE_LO] == 3'h1 && !s.wr_pend)
      |=> !tick ##1 tick;
  endproperty
  a_pre_two: assert property (p_pre_two)
    else $error("divide by two tick spacing wrong");

  property p_home_cap;
    (tick_run && home_rise && s.ioc[`IOC_CAP]) |=> s.icap == $past(s.pos);
  endproperty
  a_home_cap: assert property (p_home_cap)
    else $error("home edge did not capture position");

  property p_quad_step;
    (tick_run && ccm == `CCM_QUAD && step && quad_up && !s.ctrl[`CTRL_POL]
      && pim_eff == `PIM_NONE && !match_clr && !s.wr_pend)
      |=> s.pos == $past(s.pos) + 32'h1;
  endproperty
  a_quad_step: assert property (p_quad_step)
    else $error("x4 step did not count up");

  c_init_done: cover property (evt_set[`EVT_INIT]);
  c_mod_wrap: cover property (tick_run && cnt_en
    && pim_eff == `PIM_MOD && up && s.pos == s.gec);
  c_capture: cover property (tick_run && home_rise && s.ioc[`IOC_CAP]);
  c_timer: cover property (tick_run && ccm == `CCM_TIMER);
endmodule

// ===== dv/enc_model.sv
/*
  Incremental encoder model: gray-coded phases, index and home pulses.
  Assumes its tasks are called from the bench between clock edges.
*/
`timescale 1ns/1ps
module enc_model (
  // clock
  input wire logic hclk,
  // encoder pins
  output logic a,
  output logic b,
  output logic index,
  output logic home
);
  // phase 0..3 is ab = 00,10,11,01; forward means a leads
  int ph = 0;

  initial begin
    a = 1'b0;
    b = 1'b0;
    index = 1'b0;
    home = 1'b0;
  end

  // each level held 9 clocks, far slower than the counter clock
  task automatic put(input int p);
    ph = p & 3;
    @(posedge hclk);
    a <= (ph == 1) || (ph == 2);
    b <= (ph >= 2);
    repeat (8) @(posedge hclk);
  endtask

  task automatic move(input int n);
    int m;
    m = (n < 0) ? -n : n;
    for (int i = 0; i < m; i++) begin
      put((n < 0) ? ph - 1 : ph + 1);
    end
  endtask

  task automatic pulse(input logic h);
    @(posedge hclk);
    if (h) begin
      home <= 1'b1;
    end else begin
      index <= 1'b1;
    end
    repeat (8) @(posedge hclk);
    home <= 1'b0;
    index <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
endmodule

// ===== dv/quad_encoder_control_bench.sv
/*
  Self-checking bench of the quadrature encoder block: AHB-Lite master,
  read monitor fed by a queue of expected ranges, table of count cases.
  Assumes the encoder model and the design are compiled alongside.
*/
`timescale 1ns/1ps
`include "quad_enc_cfg.svh"
module quad_encoder_control_bench;
  typedef struct {logic [31:0] lo; logic [31:0] hi;} exp_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic a, b, index, home;
  logic ext_gate = 1'b1;
  logic device_idle = 1'b0;
  logic [15:0] seed = 16'hE0A1;
  logic [31:0] icap_v;
  logic rd_dp = 1'b0;
  exp_t q[$];
  exp_t e;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;

  always #5 hclk = ~hclk;

  quad_encoder u_quad_encoder (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phase_a_input(a),
    .phase_b_input(b), .index_input(index), .home_input(home),
    .ext_gate_input(ext_gate), .device_idle(device_idle)
  );

  enc_model enc (.hclk(hclk), .a(a), .b(b), .index(index), .home(home));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hB400) : (s >> 1);
  endfunction

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp_rd(input exp_t x);
    checks_done++;
    if ((hrdata >= x.lo) !== 1'b1 || (hrdata <= x.hi) !== 1'b1) begin
      bad_count++;
      $display("Error %0t: read %h, want %h..%h", $time, hrdata, x.lo, x.hi);
    end
  endtask

  task automatic cmp_resp;
    checks_done++;
    if (hresp !== 1'b0) begin
      bad_count++;
      $display("Error %0t: response not okay", $time);
    end
  endtask

  // address held until hready is seen, then data phase to hready
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    hsize <= sz;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, `HSIZE_WORD);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] lo, hi);
    exp_t x;
    x.lo = lo;
    x.hi = hi;
    q.push_back(x);
    bus(1'b0, ad, 32'h0, `HSIZE_WORD);
  endtask

  // pins always return to phase 0, so a stopped decoder sees no jump
  task automatic run(input logic [15:0] c, input logic il, gt,
                     input int n, input logic hm, input int k,
                     input logic [31:0] lo, hi);
    wr(`ADDR_CTRL, 32'h0);
    wr(`ADDR_POS, 32'h5);
    wr(`ADDR_ICAP, icap_v);
    wr(`ADDR_GEC, 32'h8);
    device_idle <= il;
    ext_gate <= gt;
    wr(`ADDR_CTRL, {16'h0, c});
    enc.move(n);
    if (hm) enc.pulse(1'b1);
    repeat (k) enc.pulse(1'b0);
    rd(`ADDR_POS, lo, hi);
    enc.move(-n);
  endtask

  // result of a read shows at the edge that ends its data phase
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      cmp_rd(e);
      cmp_resp();
    end
    rd_dp = htrans[1] && !hwrite && hreadyout === 1'b1;
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(`ADDR_CTRL, 32'h0, 32'h0);
    rd(8'h20, 32'h0, 32'h0);
    wr(`ADDR_CTRL, 32'hFFFF);
    rd(`ADDR_CTRL, 32'hBF7F, 32'hBF7F);
    wr(`ADDR_CTRL, 32'h0);
    // byte-sized access must be ignored
    bus(1'b1, `ADDR_CTRL, 32'hFFFF, 3'h0);
    rd(`ADDR_CTRL, 32'h0, 32'h0);
    wr(`ADDR_IOC, 32'h0110);
    repeat (12) @(posedge hclk);
    rd(`ADDR_IOC, 32'h0112, 32'h0112);
    wr(`ADDR_IOC, 32'h4070);
    repeat (12) @(posedge hclk);
    rd(`ADDR_IOC, 32'h4077, 32'h4077);
    wr(`ADDR_IOC, 32'h0);
    repeat (12) @(posedge hclk);
    seed = lfsr(seed);
    icap_v[31:16] = seed;
    seed = lfsr(seed);
    icap_v[15:0] = seed;
    run(16'h0000, 0, 1, 4, 0, 0, 5, 5);
    run(16'h8000, 0, 1, 6, 0, 0, 11, 11);
    run(16'h8000, 0, 1, -3, 0, 0, 2, 2);
    run(16'h8008, 0, 1, 4, 0, 0, 1, 1);
    run(16'hA000, 1, 1, 4, 0, 0, 5, 5);
    run(16'h8000, 1, 1, 4, 0, 0, 9, 9);
    run(16'h8004, 0, 0, 4, 0, 0, 5, 5);
    run(16'h8004, 0, 1, 4, 0, 0, 9, 9);
    run(16'h8001, 0, 1, 4, 0, 0, 4, 4);
    run(16'h8002, 0, 1, 4, 0, 0, 6, 6);
    run(16'h8433, 0, 1, 0, 0, 1, 6, 9);
    run(16'h8013, 0, 1, 0, 0, 1, 13, 15);
    run(16'h8400, 0, 1, 2, 0, 1, 0, 0);
    run(16'h8000, 0, 1, 0, 0, 1, 5, 5);
    run(16'h8800, 0, 1, 0, 0, 1, icap_v, icap_v);
    run(16'h9400, 0, 1, 3, 0, 0, 0, 0);
    run(16'h9800, 0, 1, 5, 0, 0, 1, 1);
    run(16'h9C00, 0, 1, 0, 0, 1, 5, 5);
    run(16'h8100, 0, 1, 1, 0, 1, 0, 0);
    run(16'h8200, 0, 1, 3, 0, 1, 0, 0);
    run(16'h8300, 0, 1, 1, 0, 1, 6, 6);
    run(16'h8C00, 0, 1, 0, 0, 1, 5, 5);
    run(16'h8C00, 0, 1, 0, 1, 1, icap_v, icap_v);
    run(16'h9000, 0, 1, 0, 1, 1, 5, 5);
    run(16'h9000, 0, 1, 0, 1, 2, icap_v, icap_v);
    wr(`ADDR_CTRL, 32'h8000);
    wr(`ADDR_IOC, 32'h8000);
    wr(`ADDR_POS, ~icap_v);
    enc.pulse(1'b1);
    rd(`ADDR_ICAP, ~icap_v, ~icap_v);
    rd(`ADDR_EVT, 32'h7, 32'h7);
    wr(`ADDR_EVT, 32'h7);
    rd(`ADDR_EVT, 32'h0, 32'h0);
    wr(`ADDR_POS, 32'h5);
    enc.put(2);
    rd(`ADDR_POS, 32'h5, 32'h5);
    enc.put(0);
    @(posedge hclk);
    summarize();
  end
endmodule
